// ==== verilog/cpcr_ctrl_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
// Function
// - 24-bit counter holds next instruction address
// - Fetch address forces lowest bit to zero
// - Flag bit 7 set blocks maskable interrupts
// - Non-maskable interrupt accepted unless exception start comes in the same cycle
// - Exception start forces interrupt mask set
// - Bit 6 user bit, software read/write
// - Byte ops: half carry from bit 3
// - Word ops: half carry from bit 11
// - Long ops: half carry from bit 27
// - Register seven doubles as stack pointer
module cpcr_ctrl_regs
   import cpcr_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // Program counter control
   input wire logic pc_step_i,
   input wire logic pc_load_i,
   input wire logic [PC_W-1:0] pc_load_val_i,
   // Arithmetic request
   input wire logic alu_valid_i,
   input wire cpcr_op_t alu_op_i,
   input wire cpcr_size_t alu_size_i,
   input wire logic [31:0] alu_a_i,
   input wire logic [31:0] alu_b_i,
   // Control-register instructions
   input wire logic ctl_valid_i,
   input wire cpcr_ctl_t ctl_op_i,
   input wire logic [FLAG_W-1:0] ctl_imm_i,
   // Interrupt requests and exception start
   input wire logic irq_req_i,
   input wire logic nmi_req_i,
   input wire logic exc_start_i,
   // Stack pointer use
   input wire logic sp_push_i,
   input wire logic sp_pop_i,
   input wire logic [2:0] sp_bytes_i,
   input wire logic gpr7_we_i,
   input wire logic [GPR_W-1:0] gpr7_wdata_i,
   // Outputs
   output logic [PC_W-1:0] pc_o,
   output logic [PC_W-1:0] fetch_addr_o,
   output logic [FLAG_W-1:0] flags_o,
   output logic [31:0] alu_res_o,
   output logic irq_take_o,
   output logic nmi_take_o,
   output logic [GPR_W-1:0] gpr_seven_o
);
   logic [FLAG_W-1:0] flag_r;
   logic [FLAG_W-1:0] flag_nxt;
   logic [GPR_W-1:0] sp_r;
   logic [GPR_W-1:0] sp_nxt;
   logic [31:0] res_r;
   logic [31:0] res_nxt;
   logic irq_r;
   logic irq_nxt;
   logic nmi_r;
   logic nmi_nxt;
   logic [PC_W-1:0] pc_w;
   logic [PC_W-1:0] fetch_w;
   logic [PC_W-1:0] pc_o_r;
   logic [PC_W-1:0] fetch_r;

   cpcr_alu_if alu ();

   assign alu.valid = alu_valid_i;
   assign alu.op = alu_op_i;
   assign alu.size = alu_size_i;
   assign alu.a = alu_a_i;
   assign alu.b = alu_b_i;
   assign alu.x_in = flag_r[FLG_CARRY];

   cpcr_flag_calc u_calc (
      .alu(alu.calc)
   );

   cpcr_pc_unit #(
      .PCW(PC_W)
   ) u_pc (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .step_i(pc_step_i),
      .load_i(pc_load_i),
      .load_val_i(pc_load_val_i),
      .pc_o(pc_w),
      .fetch_o(fetch_w)
   );

   // Flag register next value; exception start has top priority on I
   always_comb begin
      flag_nxt = flag_r;
      if (ctl_valid_i) begin
         case (ctl_op_i)
            CPCR_CI_LOAD: flag_nxt = ctl_imm_i;
            CPCR_CI_AND: flag_nxt = flag_r & ctl_imm_i;
            CPCR_CI_OR: flag_nxt = flag_r | ctl_imm_i;
            CPCR_CI_XOR: flag_nxt = flag_r ^ ctl_imm_i;
            default: flag_nxt = flag_r;
         endcase
      end else if (alu_valid_i) begin
         flag_nxt[FLG_HALF] = alu.f_h;
         flag_nxt[FLG_NEG] = alu.f_n;
         flag_nxt[FLG_OVF] = alu.f_v;
         flag_nxt[FLG_CARRY] = alu.f_c;
         // Extend ops only keep Z clear, never set it
         if ((alu_op_i == CPCR_OP_ADDX) || (alu_op_i == CPCR_OP_SUBX)) begin
            flag_nxt[FLG_ZERO] = flag_r[FLG_ZERO] & alu.f_z;
         end else begin
            flag_nxt[FLG_ZERO] = alu.f_z;
         end
      end
      if (exc_start_i) begin
         flag_nxt[FLG_IMASK] = 1'b1;
      end
   end

   // Compare does not write a result; others latch it
   always_comb begin
      res_nxt = res_r;
      if (alu_valid_i && (alu_op_i != CPCR_OP_CMP)) begin
         res_nxt = alu.res;
      end
   end

   // Interrupt acceptance
   always_comb begin
      irq_nxt = irq_req_i && !flag_r[FLG_IMASK] && !exc_start_i;
      nmi_nxt = nmi_req_i && !exc_start_i;
   end

   // Stack pointer: push predecrements, pop postincrements
   always_comb begin
      sp_nxt = sp_r;
      if (gpr7_we_i) begin
         sp_nxt = gpr7_wdata_i;
      end else if (sp_push_i) begin
         sp_nxt = sp_r - {29'h00000000, sp_bytes_i};
      end else if (sp_pop_i) begin
         sp_nxt = sp_r + {29'h00000000, sp_bytes_i};
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flag_r <= FLAG_RST;
         sp_r <= SP_RST;
         res_r <= 32'h00000000;
         irq_r <= 1'b0;
         nmi_r <= 1'b0;
         pc_o_r <= PC_RST;
         fetch_r <= PC_RST;
      end else begin
         flag_r <= flag_nxt;
         sp_r <= sp_nxt;
         res_r <= res_nxt;
         irq_r <= irq_nxt;
         nmi_r <= nmi_nxt;
         pc_o_r <= pc_w;
         fetch_r <= fetch_w;
      end
   end

   assign pc_o = pc_o_r;
   assign fetch_addr_o = fetch_r;
   assign flags_o = flag_r;
   assign alu_res_o = res_r;
   assign irq_take_o = irq_r;
   assign nmi_take_o = nmi_r;
   assign gpr_seven_o = sp_r;

   // Exception start forces I one cycle later
   exc_imask_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      exc_start_i |=> flags_o[FLG_IMASK]) else $error("mask not set after exception");

   // Masked request never accepted
   irq_block_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (irq_req_i && flag_r[FLG_IMASK]) |=> !irq_take_o) else $error("masked irq taken");

   // Unmasked request accepted
   irq_take_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (irq_req_i && !flag_r[FLG_IMASK] && !exc_start_i) |=> irq_take_o) else $error("irq lost");

   // NMI ignores the mask
   nmi_take_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (nmi_req_i && !exc_start_i) |=> nmi_take_o) else $error("nmi not taken");

   // Fetch address is even
   fetch_align_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      !fetch_addr_o[0]) else $error("odd fetch address");

   // Step advances by one instruction, seen two cycles on at the port
   pc_step_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (pc_step_i && !pc_load_i) |=> ##1 (pc_o == $past(pc_w, 2) + INSTR_BYTES))
      else $error("pc step wrong");

   // Software write to user bit sticks
   user_bit_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (ctl_valid_i && ctl_op_i == CPCR_CI_LOAD) |=> (flags_o[FLG_UMASK] == $past(ctl_imm_i[FLG_UMASK])))
      else $error("user bit not loaded");

   // Byte half carry from bit 3 on add
   half_byte_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (alu_valid_i && !ctl_valid_i && alu_op_i == CPCR_OP_ADD && alu_size_i == CPCR_SZ_BYTE)
      |=> (flags_o[FLG_HALF] == ($past({1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]}) > 5'h0F)))
      else $error("byte half carry wrong");

   // Push lowers the stack pointer
   sp_push_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (sp_push_i && !gpr7_we_i) |=> (gpr_seven_o == $past(sp_r) - {29'h00000000, $past(sp_bytes_i)}))
      else $error("stack push wrong");
endmodule
`default_nettype wire

// ==== verilog/cpcr_pkg.sv ====
package cpcr_pkg;
   // Widths
   localparam int PC_W = 24;
   localparam int FLAG_W = 8;
   localparam int GPR_W = 32;
   // Flag register field positions
   localparam int FLG_IMASK = 7;
   localparam int FLG_UMASK = 6;
   localparam int FLG_HALF = 5;
   localparam int FLG_NEG = 3;
   localparam int FLG_ZERO = 2;
   localparam int FLG_OVF = 1;
   localparam int FLG_CARRY = 0;
   // Half-carry source bit per operand size
   localparam int HC_BYTE_BIT = 3;
   localparam int HC_WORD_BIT = 11;
   localparam int HC_LONG_BIT = 27;
   // Reset values
   localparam logic [7:0] FLAG_RST = 8'h80;
   localparam logic [23:0] PC_RST = 24'h000000;
   localparam logic [31:0] SP_RST = 32'h00000000;
   // Instruction length in bytes
   localparam logic [23:0] INSTR_BYTES = 24'h000002;
   // Operand sizes
   typedef enum logic [1:0] {
      CPCR_SZ_BYTE = 2'h0,
      CPCR_SZ_WORD = 2'h1,
      CPCR_SZ_LONG = 2'h2
   } cpcr_size_t;
   // Arithmetic ops that update flags
   typedef enum logic [2:0] {
      CPCR_OP_ADD = 3'h0,
      CPCR_OP_ADDX = 3'h1,
      CPCR_OP_SUB = 3'h2,
      CPCR_OP_SUBX = 3'h3,
      CPCR_OP_CMP = 3'h4,
      CPCR_OP_NEG = 3'h5
   } cpcr_op_t;
   // Control-register instructions on the flag register
   typedef enum logic [2:0] {
      CPCR_CI_LOAD = 3'h0,
      CPCR_CI_AND = 3'h1,
      CPCR_CI_OR = 3'h2,
      CPCR_CI_XOR = 3'h3
   } cpcr_ctl_t;
endpackage

// ==== verilog/cpcr_alu_if.sv ====
`timescale 1ns/1ns
`default_nettype none
// Carries one arithmetic request and its flag results
interface cpcr_alu_if;
   import cpcr_pkg::*;
   logic valid;
   cpcr_op_t op;
   cpcr_size_t size;
   logic [31:0] a;
   logic [31:0] b;
   logic x_in;
   logic [31:0] res;
   logic f_h;
   logic f_n;
   logic f_z;
   logic f_v;
   logic f_c;
   modport req (output valid, op, size, a, b, x_in, input res, f_h, f_n, f_z, f_v, f_c);
   modport calc (input valid, op, size, a, b, x_in, output res, f_h, f_n, f_z, f_v, f_c);
endinterface
`default_nettype wire

// ==== verilog/cpcr_flag_calc.sv ====
`timescale 1ns/1ns
`default_nettype none
// Combinational result and flags for add/sub/cmp/neg
module cpcr_flag_calc
   import cpcr_pkg::*;
(
   cpcr_alu_if.calc alu
);
   logic [32:0] sum;
   logic [31:0] opa;
   logic [31:0] opb;
   logic sub;
   logic carry_in;
   logic [4:0] lo_b;
   logic [12:0] lo_w;
   logic [28:0] lo_l;
   logic [5:0] top;
   logic sa;
   logic sb;
   logic sr;

   // Select msb index for a size
   function automatic logic [5:0] msb_of(input cpcr_size_t s);
      case (s)
         CPCR_SZ_BYTE: msb_of = 6'h07;
         CPCR_SZ_WORD: msb_of = 6'h0F;
         default: msb_of = 6'h1F;
      endcase
   endfunction

   // Operand setup: subtraction as a + ~b + 1
   always_comb begin
      sub = (alu.op != CPCR_OP_ADD) && (alu.op != CPCR_OP_ADDX);
      opa = (alu.op == CPCR_OP_NEG) ? 32'h00000000 : alu.a;
      opb = (alu.op == CPCR_OP_NEG) ? alu.a : alu.b;
      if (sub) begin
         opb = ~opb;
      end
      case (alu.op)
         CPCR_OP_ADDX: carry_in = alu.x_in;
         CPCR_OP_SUBX: carry_in = ~alu.x_in;
         CPCR_OP_ADD: carry_in = 1'b0;
         default: carry_in = 1'b1;
      endcase
      sum = {1'b0, opa} + {1'b0, opb} + {32'h00000000, carry_in};
      // Carry out of bit 3, 11, 27; borrow is the inverse
      lo_b = {1'b0, opa[HC_BYTE_BIT:0]} + {1'b0, opb[HC_BYTE_BIT:0]} + {4'h0, carry_in};
      lo_w = {1'b0, opa[HC_WORD_BIT:0]} + {1'b0, opb[HC_WORD_BIT:0]} + {12'h000, carry_in};
      lo_l = {1'b0, opa[HC_LONG_BIT:0]} + {1'b0, opb[HC_LONG_BIT:0]} + {28'h0000000, carry_in};
      case (alu.size)
         CPCR_SZ_BYTE: alu.f_h = lo_b[4] ^ sub;
         CPCR_SZ_WORD: alu.f_h = lo_w[12] ^ sub;
         default: alu.f_h = lo_l[28] ^ sub;
      endcase
      top = msb_of(alu.size);
      sa = opa[top[4:0]];
      sb = opb[top[4:0]];
      sr = sum[top[4:0]];
      case (alu.size)
         CPCR_SZ_BYTE: alu.res = {24'h000000, sum[7:0]};
         CPCR_SZ_WORD: alu.res = {16'h0000, sum[15:0]};
         default: alu.res = sum[31:0];
      endcase
      // N, V, C in the customary way
      alu.f_n = sr;
      alu.f_v = (sa == sb) && (sr != sa);
      case (alu.size)
         CPCR_SZ_BYTE: alu.f_c = ({1'b0, opa[7:0]} + {1'b0, opb[7:0]} + {8'h00, carry_in}) > 9'h0FF;
         CPCR_SZ_WORD: alu.f_c = ({1'b0, opa[15:0]} + {1'b0, opb[15:0]} + {16'h0000, carry_in}) > 17'h0FFFF;
         default: alu.f_c = sum[32];
      endcase
      alu.f_c = alu.f_c ^ sub;
      alu.f_z = (alu.res == 32'h00000000);
   end
endmodule
`default_nettype wire

// ==== verilog/cpcr_pc_unit.sv ====
`timescale 1ns/1ns
`default_nettype none
// Program counter: next address, always word aligned on fetch
module cpcr_pc_unit
   import cpcr_pkg::*;
#(
   parameter int PCW = PC_W
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic step_i,
   input wire logic load_i,
   input wire logic [PCW-1:0] load_val_i,
   output logic [PCW-1:0] pc_o,
   output logic [PCW-1:0] fetch_o
);
   logic [PCW-1:0] pc_r;
   logic [PCW-1:0] pc_nxt;

   // Next address: load wins over step
   always_comb begin
      pc_nxt = pc_r;
      if (load_i) begin
         pc_nxt = load_val_i;
      end else if (step_i) begin
         pc_nxt = pc_r + INSTR_BYTES[PCW-1:0];
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pc_r <= PC_RST[PCW-1:0];
      end else begin
         pc_r <= pc_nxt;
      end
   end

   assign pc_o = pc_r;
   assign fetch_o = {pc_r[PCW-1:1], 1'b0};
endmodule
`default_nettype wire

// ==== tb/cpcr_seq_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Decoder and exception sequencer: one request per call, then idle
module cpcr_seq_model
   import cpcr_pkg::*;
(
   // Clock
   input wire logic ref_clk_i,
   // Program counter requests
   output var logic pc_step_o,
   output var logic pc_load_o,
   output var logic [PC_W-1:0] pc_val_o,
   // Arithmetic and flag instructions
   output var logic alu_valid_o,
   output var cpcr_op_t alu_op_o,
   output var cpcr_size_t alu_size_o,
   output var logic [31:0] alu_a_o,
   output var logic [31:0] alu_b_o,
   output var logic ctl_valid_o,
   output var cpcr_ctl_t ctl_op_o,
   output var logic [FLAG_W-1:0] ctl_imm_o,
   // Events and stack
   output var logic irq_o,
   output var logic nmi_o,
   output var logic exc_o,
   output var logic push_o,
   output var logic pop_o,
   output var logic [2:0] bytes_o,
   output var logic gpr7_we_o,
   output var logic [GPR_W-1:0] gpr7_d_o
);
   // Idle values at time zero
   initial begin
      {pc_step_o, pc_load_o, pc_val_o, alu_valid_o, alu_a_o, alu_b_o, ctl_valid_o, ctl_imm_o} = '0;
      {irq_o, nmi_o, exc_o, push_o, pop_o, bytes_o, gpr7_we_o, gpr7_d_o} = '0;
      alu_op_o = CPCR_OP_ADD;
      alu_size_o = CPCR_SZ_BYTE;
      ctl_op_o = CPCR_CI_LOAD;
   end
   // Operands turn over once released, so stale values never help
   task automatic alu(input cpcr_op_t o, input cpcr_size_t s, input logic [31:0] a, input logic [31:0] b);
      @(negedge ref_clk_i);
      {alu_op_o, alu_size_o, alu_a_o, alu_b_o, alu_valid_o} = {o, s, a, b, 1'b1};
      @(negedge ref_clk_i);
      {alu_a_o, alu_b_o, alu_valid_o} = {~a, ~b, 1'b0};
   endtask
   // Flag register instruction
   task automatic ctl(input cpcr_ctl_t o, input logic [7:0] imm);
      @(negedge ref_clk_i);
      {ctl_op_o, ctl_imm_o, ctl_valid_o} = {o, imm, 1'b1};
      @(negedge ref_clk_i);
      {ctl_imm_o, ctl_valid_o} = {~imm, 1'b0};
   endtask
   // Interrupt levels and exception start for one cycle
   task automatic evt(input logic irq, input logic nmi, input logic exc);
      @(negedge ref_clk_i);
      {irq_o, nmi_o, exc_o} = {irq, nmi, exc};
      @(negedge ref_clk_i);
      {irq_o, nmi_o, exc_o} = 3'h0;
   endtask
   // Step or jump; waits out the two-cycle answer
   task automatic pc(input logic ld, input logic [PC_W-1:0] v);
      @(negedge ref_clk_i);
      {pc_step_o, pc_load_o, pc_val_o} = {~ld, ld, v};
      @(negedge ref_clk_i);
      {pc_step_o, pc_load_o, pc_val_o} = {2'h0, ~v};
      @(negedge ref_clk_i);
   endtask
   // Stack pointer write, push or pop
   task automatic sp(input logic we, input logic pu, input logic po, input logic [2:0] n, input logic [31:0] d);
      @(negedge ref_clk_i);
      {gpr7_we_o, push_o, pop_o, bytes_o, gpr7_d_o} = {we, pu, po, n, d};
      @(negedge ref_clk_i);
      {gpr7_we_o, push_o, pop_o, gpr7_d_o} = {3'h0, ~d};
   endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %h got %h", n, e, g); end end
module testbench;
   import cpcr_pkg::*;
   // Clock, reset and counters
   logic ref_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   int fails = 0;
   int checks_done = 0;
   // Requests from the model
   logic pc_step_i, pc_load_i, alu_valid_i, ctl_valid_i, irq_req_i, nmi_req_i, exc_start_i;
   logic sp_push_i, sp_pop_i, gpr7_we_i, irq_take_o, nmi_take_o;
   logic [PC_W-1:0] pc_load_val_i, pc_o, fetch_addr_o;
   logic [31:0] alu_a_i, alu_b_i, alu_res_o;
   logic [FLAG_W-1:0] ctl_imm_i, flags_o;
   logic [2:0] sp_bytes_i;
   logic [GPR_W-1:0] gpr7_wdata_i, gpr_seven_o;
   cpcr_op_t alu_op_i;
   cpcr_size_t alu_size_i;
   cpcr_ctl_t ctl_op_i;
   logic hx;
   logic [3:0] nzvc;
   assign nzvc = {flags_o[FLG_NEG], flags_o[FLG_ZERO], flags_o[FLG_OVF], flags_o[FLG_CARRY]};
   // Control instruction table with the flag value each leaves
   cpcr_ctl_t cops[4] = '{CPCR_CI_LOAD, CPCR_CI_AND, CPCR_CI_OR, CPCR_CI_XOR};
   logic [7:0] cimm[4] = '{8'h5A, 8'hF0, 8'h81, 8'hFF};
   logic [7:0] cexp[4] = '{8'h5A, 8'h50, 8'hD1, 8'h2E};
   logic [31:0] opa[2] = '{32'h0F0F0F0F, 32'h02020202};
   logic [31:0] opb[2] = '{32'h01010101, 32'h03030303};
   always #50 ref_clk_i = ~ref_clk_i;
   cpcr_seq_model seq_u (.ref_clk_i, .pc_step_o(pc_step_i), .pc_load_o(pc_load_i), .pc_val_o(pc_load_val_i),
      .alu_valid_o(alu_valid_i), .alu_op_o(alu_op_i), .alu_size_o(alu_size_i), .alu_a_o(alu_a_i),
      .alu_b_o(alu_b_i), .ctl_valid_o(ctl_valid_i), .ctl_op_o(ctl_op_i), .ctl_imm_o(ctl_imm_i),
      .irq_o(irq_req_i), .nmi_o(nmi_req_i), .exc_o(exc_start_i), .push_o(sp_push_i), .pop_o(sp_pop_i),
      .bytes_o(sp_bytes_i), .gpr7_we_o(gpr7_we_i), .gpr7_d_o(gpr7_wdata_i));
   cpcr_ctrl_regs dut_u (.ref_clk_i, .arst_n_i, .pc_step_i, .pc_load_i, .pc_load_val_i, .alu_valid_i,
      .alu_op_i, .alu_size_i, .alu_a_i, .alu_b_i, .ctl_valid_i, .ctl_op_i, .ctl_imm_i, .irq_req_i,
      .nmi_req_i, .exc_start_i, .sp_push_i, .sp_pop_i, .sp_bytes_i, .gpr7_we_i, .gpr7_wdata_i, .pc_o,
      .fetch_addr_o, .flags_o, .alu_res_o, .irq_take_o, .nmi_take_o, .gpr_seven_o);
   // Carry or borrow out of the half-carry bit for the operand size
   function automatic logic exp_h(input cpcr_op_t o, input cpcr_size_t s, input logic [31:0] a,
      input logic [31:0] b, input logic c);
      int w = (s == CPCR_SZ_BYTE) ? HC_BYTE_BIT + 1 : (s == CPCR_SZ_WORD) ? HC_WORD_BIT + 1 : HC_LONG_BIT + 1;
      logic [32:0] m = (33'h1 << w) - 33'h1;
      logic x = (o == CPCR_OP_ADDX || o == CPCR_OP_SUBX) ? c : 1'b0;
      logic [32:0] am = {1'b0, a} & m;
      logic [32:0] bm = {1'b0, b} & m;
      logic [32:0] sum = am + bm + 33'(x);
      if (o == CPCR_OP_NEG) return am != 33'h0;
      if (o == CPCR_OP_ADD || o == CPCR_OP_ADDX) return sum[w];
      return am < bm + 33'(x);
   endfunction
   // Verdict and end of run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog well beyond the fewer than two hundred cycles the tests need
   initial begin
      repeat (3000) @(posedge ref_clk_i);
      fails++;
      end_sim();
   end
   // Test sequence
   initial begin
      repeat (3) @(negedge ref_clk_i);
      `CHK("flags_rst", 8'h80, flags_o)
      arst_n_i = 1'b1;
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         seq_u.ctl(cops[i], cimm[i]);
         `CHK("flags_ctl", cexp[i], flags_o)
      end
      $display("test control done");
      seq_u.evt(1'b1, 1'b0, 1'b0);
      `CHK("irq_open", 1'b1, irq_take_o)
      seq_u.ctl(CPCR_CI_OR, 8'h80);
      seq_u.evt(1'b1, 1'b0, 1'b0);
      `CHK("irq_masked", 1'b0, irq_take_o)
      seq_u.evt(1'b0, 1'b1, 1'b0);
      `CHK("nmi_masked", 1'b1, nmi_take_o)
      seq_u.ctl(CPCR_CI_LOAD, 8'h00);
      seq_u.evt(1'b1, 1'b1, 1'b1);
      `CHK("flags_exc", 8'h80, flags_o)
      `CHK("irq_exc", 1'b0, irq_take_o)
      $display("test interrupt done");
      for (int p = 0; p < 2; p++) for (int o = 0; o < 6; o++) for (int s = 0; s < 3; s++) begin
         seq_u.ctl(CPCR_CI_LOAD, {7'h0, p[0]});
         seq_u.alu(cpcr_op_t'(o), cpcr_size_t'(s), opa[p], opb[p]);
         hx = exp_h(cpcr_op_t'(o), cpcr_size_t'(s), opa[p], opb[p], p[0]);
         `CHK("half", hx, flags_o[FLG_HALF])
      end
      seq_u.alu(CPCR_OP_ADD, CPCR_SZ_BYTE, 32'hFF, 32'h01);
      `CHK("nzvc_a", 4'b0101, nzvc)
      seq_u.alu(CPCR_OP_ADD, CPCR_SZ_BYTE, 32'h7F, 32'h01);
      `CHK("nzvc_b", 4'b1010, nzvc)
      seq_u.alu(CPCR_OP_SUB, CPCR_SZ_LONG, 32'h0, 32'h1);
      `CHK("nzvc_c", 4'b1001, nzvc)
      $display("test arithmetic done");
      seq_u.pc(1'b1, 24'h123457);
      `CHK("pc_load", 24'h123457, pc_o)
      `CHK("fetch_load", 24'h123456, fetch_addr_o)
      seq_u.pc(1'b0, 24'h0);
      `CHK("pc_step", 24'h123459, pc_o)
      `CHK("fetch_step", 24'h123458, fetch_addr_o)
      seq_u.pc(1'b1, 24'hFFFFFE);
      seq_u.pc(1'b0, 24'h0);
      `CHK("pc_wrap", 24'h000000, pc_o)
      $display("test counter done");
      seq_u.sp(1'b1, 1'b0, 1'b0, 3'h0, 32'h1000);
      `CHK("sp_write", 32'h1000, gpr_seven_o)
      seq_u.sp(1'b0, 1'b1, 1'b0, 3'h4, 32'h0);
      `CHK("sp_push", 32'h0FFC, gpr_seven_o)
      seq_u.sp(1'b0, 1'b0, 1'b1, 3'h4, 32'h0);
      `CHK("sp_pop", 32'h1000, gpr_seven_o)
      $display("test stack done");
      end_sim();
   end
endmodule
`default_nettype wire
